/* File: rtl/vcarb_regs.sv */
// channel arbitration configuration registers of one switch port
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
`include "vcarb_defs.svh"
module vcarb_regs #(
    parameter int ADDR_W = `VCARB_ADDR_W
) (
    // clock and reset
    input  wire logic                clk_i,
    input  wire logic                arst_n_i,
    // register port
    input  wire logic [ADDR_W-1:0]   addr_i,
    input  wire logic [31:0]         wdata_i,
    input  wire logic                wr_i,
    input  wire logic                rd_i,
    output logic [31:0]              rdata_o,
    // privileged path for lock-writable fields
    input  wire logic                priv_wr_i,
    // fixed capability inputs from the port
    input  wire logic [2:0]          low_prio_extra_chan_count_i,
    input  wire vcarb_pkg::vcarb_byte_t chan_arb_capability_i,
    // steering outputs
    output vcarb_pkg::vcarb_sel_t    chan_arb_scheme_select_o,
    output vcarb_pkg::vcarb_byte_t   port_arb_capability_o
);
    import vcarb_pkg::*;

    // the decoder compares twelve address bits, so a narrower port cannot reach the bank
    if (ADDR_W < 12) begin : g_addr_check
        $error("ADDR_W too narrow for offsets");
    end

    vcarb_sel_t  sel_reg;
    vcarb_byte_t parb_cap_reg;
    vcarb_byte_t patbl_off_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;

    function automatic logic is_at(input logic [11:0] a, input logic [11:0] off);
        return (a == off);
    endfunction

    wire logic [11:0] a12      = addr_i[11:0];
    wire logic        hit_ctrl = is_at(a12, `VCARB_OFF_CTRL);
    wire logic        hit_res0 = is_at(a12, `VCARB_OFF_RES0_CAP);
    wire logic        hit_cap2 = is_at(a12, `VCARB_OFF_CAP_TWO);
    wire logic        hit_stat = is_at(a12, `VCARB_OFF_STAT);

    // only the select field is software-writable; load bit stays unstored
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sel_reg <= `VCARB_SEL_RST;
        end else if (wr_i && hit_ctrl) begin
            sel_reg <= wdata_i[`VCARB_SEL_MSB:`VCARB_SEL_LSB]; // [R4] [R2] [R3] [R12]
        end
    end

    // lock-writable fields ignore ordinary writes
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            parb_cap_reg  <= `VCARB_PARB_CAP_RST;  // [R6]
            patbl_off_reg <= `VCARB_PATBL_OFF_RST; // [R10]
        end else if (wr_i && priv_wr_i && hit_res0) begin
            parb_cap_reg  <= wdata_i[7:0];                          // [R13]
            patbl_off_reg <= wdata_i[`VCARB_OFF_MSB:`VCARB_OFF_LSB]; // [R10] [R13]
        end
    end

    // capability is reported only when a low priority group exists
    function automatic logic [31:0] cap_two_word(input logic [2:0] cnt, input vcarb_byte_t cap);
        logic [31:0] w;
        w = 32'h0;
        if (cnt != 3'h0) begin
            w[7:0] = cap; // [R11]
        end
        w[`VCARB_OFF_MSB:`VCARB_OFF_LSB] = `VCARB_CAB_TBL_OFF; // [R1]
        return w;
    endfunction

    // the two 16-bit words share one dword; the status half sits at bits 31:16
    always_comb begin
        rdata_next = 32'h0;
        if (a12 == `VCARB_OFF_CAP_TWO) begin
            rdata_next = cap_two_word(low_prio_extra_chan_count_i, chan_arb_capability_i);
        end else if (hit_ctrl) begin
            rdata_next[`VCARB_SEL_MSB:`VCARB_SEL_LSB] = sel_reg; // [R4]
            rdata_next[`VCARB_LOAD_BIT] = 1'b0;                  // [R2]
            rdata_next[16] = 1'b0;                               // [R5]
        end else if (a12 == `VCARB_OFF_STAT) begin
            rdata_next[0] = 1'b0; // [R5]
        end else if (hit_res0) begin
            rdata_next[7:0] = parb_cap_reg;                            // [R6]
            rdata_next[`VCARB_TSLOT_MSB:`VCARB_TSLOT_LSB] = 7'h00;     // [R9] [R7] [R8]
            rdata_next[`VCARB_OFF_MSB:`VCARB_OFF_LSB] = patbl_off_reg; // [R10] [R12]
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_reg <= 32'h0;
        end else begin
            rdata_reg <= rd_i ? rdata_next : 32'h0;
        end
    end

    assign rdata_o                  = rdata_reg;
    assign chan_arb_scheme_select_o = sel_reg;
    assign port_arb_capability_o    = parb_cap_reg;

    // read slot bookkeeping: the address whose data now stands on rdata_o
    logic        slot_reg;
    logic [11:0] slot_addr_reg;
    logic [31:0] live_mask;
    logic        slot_cap2;
    logic        slot_ctrl;
    logic        slot_stat;
    logic        slot_res0;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            slot_reg      <= 1'b0;
            slot_addr_reg <= 12'h000;
        end else begin
            slot_reg      <= rd_i;
            slot_addr_reg <= a12;
        end
    end

    // bits that may be nonzero in a read of each word; everything else must read zero
    function automatic logic [31:0] live_bits(input logic [11:0] a);
        logic [31:0] m;
        m = 32'h0;
        if (is_at(a, `VCARB_OFF_CAP_TWO)) begin
            m = `VCARB_CAP_TWO_LIVE;
        end else if (is_at(a, `VCARB_OFF_CTRL)) begin
            m = `VCARB_CTRL_LIVE;
        end else if (is_at(a, `VCARB_OFF_STAT)) begin
            m = `VCARB_STAT_LIVE;
        end else if (is_at(a, `VCARB_OFF_RES0_CAP)) begin
            m = `VCARB_RES0_LIVE;
        end
        return m;
    endfunction

    assign live_mask = live_bits(slot_addr_reg);
    assign slot_cap2 = slot_reg && is_at(slot_addr_reg, `VCARB_OFF_CAP_TWO);
    assign slot_ctrl = slot_reg && is_at(slot_addr_reg, `VCARB_OFF_CTRL);
    assign slot_stat = slot_reg && is_at(slot_addr_reg, `VCARB_OFF_STAT);
    assign slot_res0 = slot_reg && is_at(slot_addr_reg, `VCARB_OFF_RES0_CAP);

    // one check per data bit, so a stray bit names itself in the failure
    for (genvar i = 0; i < 32; i++) begin : g_resv_bit
        a_resv_bit: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [R12]
            slot_reg && !live_mask[i] |-> !rdata_o[i]) else $error("reserved bit reads one");
    end

    a_sel_write: assert property ( // [R4]
        @(posedge clk_i) disable iff (!arst_n_i)
        wr_i && hit_ctrl
        |=> sel_reg == $past(wdata_i[3:1])
    ) else $error("select not written");

    a_load_zero: assert property ( // [R2]
        @(posedge clk_i) disable iff (!arst_n_i)
        $past(rd_i) && $past(hit_ctrl)
        |-> rdata_o[0] == 1'b0
    ) else $error("load bit read nonzero");

    a_res0_fixed: assert property ( // [R9]
        @(posedge clk_i) disable iff (!arst_n_i)
        $past(rd_i) && $past(hit_res0)
        |-> rdata_o[23:8] == 16'h0
    ) else $error("res0 fixed bits nonzero");

    a_lock_hold: assert property ( // [R13]
        @(posedge clk_i) disable iff (!arst_n_i)
        wr_i && !priv_wr_i
        |=> $stable(patbl_off_reg) && $stable(parb_cap_reg)
    ) else $error("lock field moved");

    a_tbl_off_zero: assert property ( // [R1]
        @(posedge clk_i) disable iff (!arst_n_i)
        $past(rd_i) && $past(hit_cap2)
        |-> rdata_o[31:8] == 24'h0
    ) else $error("table offset nonzero");

    a_stat_zero: assert property ( // [R5]
        @(posedge clk_i) disable iff (!arst_n_i)
        $past(rd_i) && $past(hit_stat)
        |-> rdata_o == 32'h0
    ) else $error("status nonzero");

    a_cap_gate: assert property ( // [R11]
        @(posedge clk_i) disable iff (!arst_n_i)
        $past(rd_i) && $past(hit_cap2)
        && $past(low_prio_extra_chan_count_i) == 3'h0
        |-> rdata_o[7:0] == 8'h0
    ) else $error("capability shown without group");

    a_idle_zero: assert property ( // [R12]
        @(posedge clk_i) disable iff (!arst_n_i)
        !$past(rd_i)
        |-> rdata_o == 32'h0
    ) else $error("read data outside read slot");

    a_ctrl_sel_rd: assert property ( // [R4]
        @(posedge clk_i) disable iff (!arst_n_i)
        slot_ctrl
        |-> rdata_o[3:1] == sel_reg
    ) else $error("select reads wrong");

    a_ctrl_load_rd: assert property ( // [R2]
        @(posedge clk_i) disable iff (!arst_n_i)
        slot_ctrl
        |-> !rdata_o[0]
    ) else $error("load bit reads one");

    a_ctrl_upper_zero: assert property ( // [R5]
        @(posedge clk_i) disable iff (!arst_n_i)
        slot_ctrl
        |-> rdata_o[31:16] == 16'h0
    ) else $error("status half nonzero");

    a_ctrl_resv: assert property ( // [R12]
        @(posedge clk_i) disable iff (!arst_n_i)
        slot_ctrl
        |-> rdata_o[15:4] == 12'h000
    ) else $error("control reserved bits set");

    a_stat_rd_zero: assert property ( // [R5]
        @(posedge clk_i) disable iff (!arst_n_i)
        slot_stat
        |-> !rdata_o[0]
    ) else $error("coherent bit reads one");

    a_stat_resv: assert property ( // [R12]
        @(posedge clk_i) disable iff (!arst_n_i)
        slot_stat
        |-> rdata_o[15:1] == 15'h0000
    ) else $error("status reserved bits set");

    a_res0_cap_rd: assert property ( // [R6]
        @(posedge clk_i) disable iff (!arst_n_i)
        slot_res0
        |-> rdata_o[7:0] == parb_cap_reg
    ) else $error("port capability reads wrong");

    a_res0_off_rd: assert property ( // [R10]
        @(posedge clk_i) disable iff (!arst_n_i)
        slot_res0
        |-> rdata_o[31:24] == patbl_off_reg
    ) else $error("port table offset reads wrong");

    a_res0_adv_pkt: assert property ( // [R7]
        @(posedge clk_i) disable iff (!arst_n_i)
        slot_res0
        |-> !rdata_o[14]
    ) else $error("advanced switching bit set");

    a_res0_snoop: assert property ( // [R8]
        @(posedge clk_i) disable iff (!arst_n_i)
        slot_res0
        |-> !rdata_o[15]
    ) else $error("snoop reject bit set");

    a_res0_slots: assert property ( // [R9]
        @(posedge clk_i) disable iff (!arst_n_i)
        slot_res0
        |-> rdata_o[22:16] == 7'h00
    ) else $error("time slots nonzero");

    a_res0_resv: assert property ( // [R12]
        @(posedge clk_i) disable iff (!arst_n_i)
        slot_res0
        |-> rdata_o[13:8] == 6'h00 && !rdata_o[23]
    ) else $error("res0 reserved bits set");

    a_cap_shown: assert property ( // [R11]
        @(posedge clk_i) disable iff (!arst_n_i)
        slot_cap2 && $past(low_prio_extra_chan_count_i) != 3'h0
        |-> rdata_o[7:0] == $past(chan_arb_capability_i)
    ) else $error("capability not shown");

    a_cap_off_zero: assert property ( // [R1]
        @(posedge clk_i) disable iff (!arst_n_i)
        slot_cap2
        |-> rdata_o[31:24] == 8'h00
    ) else $error("channel table offset nonzero");

    a_cap2_resv: assert property ( // [R12]
        @(posedge clk_i) disable iff (!arst_n_i)
        slot_cap2
        |-> rdata_o[23:8] == 16'h0
    ) else $error("capability two reserved bits set");

    a_unmapped_zero: assert property ( // [R12]
        @(posedge clk_i) disable iff (!arst_n_i)
        slot_reg && !slot_cap2 && !slot_ctrl && !slot_stat && !slot_res0
        |-> rdata_o == 32'h0
    ) else $error("unmapped read nonzero");

    a_sel_hold: assert property ( // [R4]
        @(posedge clk_i) disable iff (!arst_n_i)
        !(wr_i && hit_ctrl)
        |=> $stable(sel_reg)
    ) else $error("select moved without write");

    a_load_no_effect: assert property ( // [R3]
        @(posedge clk_i) disable iff (!arst_n_i)
        wr_i && hit_ctrl && wdata_i[`VCARB_LOAD_BIT]
        |=> $stable(parb_cap_reg) && $stable(patbl_off_reg)
    ) else $error("load bit had an effect");

    a_priv_cap: assert property ( // [R13]
        @(posedge clk_i) disable iff (!arst_n_i)
        wr_i && priv_wr_i && hit_res0
        |=> parb_cap_reg == $past(wdata_i[7:0])
    ) else $error("privileged capability not written");

    a_priv_off: assert property ( // [R10]
        @(posedge clk_i) disable iff (!arst_n_i)
        wr_i && priv_wr_i && hit_res0
        |=> patbl_off_reg == $past(wdata_i[31:24])
    ) else $error("privileged offset not written");

    a_lock_other: assert property ( // [R13]
        @(posedge clk_i) disable iff (!arst_n_i)
        !(wr_i && priv_wr_i && hit_res0)
        |=> $stable(parb_cap_reg) && $stable(patbl_off_reg)
    ) else $error("lock field moved off the privileged path");

    a_priv_no_sel: assert property ( // [R12]
        @(posedge clk_i) disable iff (!arst_n_i)
        wr_i && hit_res0
        |=> $stable(sel_reg)
    ) else $error("res0 write moved select");

    a_stat_wr_ignored: assert property ( // [R5]
        @(posedge clk_i) disable iff (!arst_n_i)
        wr_i && hit_stat
        |=> $stable(sel_reg) && $stable(parb_cap_reg) && $stable(patbl_off_reg)
    ) else $error("status write had an effect");

    a_cap2_wr_ignored: assert property ( // [R1]
        @(posedge clk_i) disable iff (!arst_n_i)
        wr_i && hit_cap2
        |=> $stable(sel_reg) && $stable(parb_cap_reg) && $stable(patbl_off_reg)
    ) else $error("capability two write had an effect");
endmodule

/* File: rtl/vcarb_defs.svh */
// register offsets, field positions and reset values of the channel arbitration registers
// Summary of operation
// R1 - channel arbitration table offset, bits 31:24 of capability two, reads zero
// R2 - table load bit, control bit 0, always reads zero
// R3 - setting the table load bit has no functional effect
// R4 - scheme select bits 3:1 read-write, reset zero; software picks advertised schemes
// R5 - table coherent status bit 0 is read-only, resets zero
// R6 - port arbitration capability bits 7:0 reset to 0x1, bit 0 round robin
// R7 - advanced packet switching bit 14 reads zero
// R8 - snoop reject bit 15 reads zero
// R9 - maximum time slots bits 22:16 read zero
// R10 - port arbitration table offset bits 31:24, lock-writable, reset zero
// R11 - channel arbitration capability valid only when low priority count above zero
// R12 - writes to read-only and reserved fields ignored; reserved bits read zero
// R13 - lock-writable fields change only through the privileged path
`ifndef VCARB_DEFS_SVH
`define VCARB_DEFS_SVH

`define VCARB_ADDR_W          12
`define VCARB_OFF_CAP_TWO     12'h208
`define VCARB_OFF_CTRL        12'h20c
`define VCARB_OFF_STAT        12'h20e
`define VCARB_OFF_RES0_CAP    12'h210
`define VCARB_SEL_LSB         1
`define VCARB_SEL_MSB         3
`define VCARB_LOAD_BIT        0
`define VCARB_SEL_RST         3'h0
`define VCARB_PARB_CAP_RST    8'h01
`define VCARB_PATBL_OFF_RST   8'h00
`define VCARB_CAB_TBL_OFF     8'h00
`define VCARB_TSLOT_MSB       22
`define VCARB_TSLOT_LSB       16
`define VCARB_OFF_MSB         31
`define VCARB_OFF_LSB         24
`define VCARB_CAP_TWO_LIVE    32'h000000ff
`define VCARB_CTRL_LIVE       32'h0000000e
`define VCARB_STAT_LIVE       32'h00000000
`define VCARB_RES0_LIVE       32'hff0000ff

`endif

/* File: rtl/vcarb_pkg.sv */
// types shared by the channel arbitration register bank
package vcarb_pkg;
    typedef logic [2:0] vcarb_sel_t;
    typedef logic [7:0] vcarb_byte_t;
endpackage

/* File: tb/tb_vcarb_regs.sv */
// self-checking bench for the channel arbitration register bank
`timescale 1ns/1ps
`include "vcarb_defs.svh"
module tb_vcarb_regs;
    import vcarb_pkg::*;
    logic          clk_i = 1'b0;
    logic          arst_n_i = 1'b0;
    logic [11:0]   addr_i = 12'h000;
    logic [31:0]   wdata_i = 32'h0;
    logic          wr_i = 1'b0;
    logic          rd_i = 1'b0;
    logic          priv_wr_i = 1'b0;
    logic [2:0]    cnt_i = 3'h0;
    vcarb_byte_t   cap_i = 8'ha5;
    logic [31:0]   rdata_o;
    vcarb_sel_t    sel_o;
    vcarb_byte_t   pcap_o;
    int            n_errors = 0;
    int            num_checks = 0;
    vcarb_regs u_vcarb_regs (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .priv_wr_i(priv_wr_i),
        .low_prio_extra_chan_count_i(cnt_i), .chan_arb_capability_i(cap_i),
        .chan_arb_scheme_select_o(sel_o), .port_arb_capability_o(pcap_o));
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic p);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        priv_wr_i <= p;
        @(posedge clk_i);
        wr_i <= 1'b0;
        priv_wr_i <= 1'b0;
        #1;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 chk(rdata_o, exp);
    endtask
    task automatic results;
        $display("checks %0d, errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk_i);
        arst_n_i <= 1'b1;
        #1 chk({24'h0, pcap_o}, 32'h1);
        rd(`VCARB_OFF_CTRL, 32'h0);
        rd(`VCARB_OFF_STAT, 32'h0);
        rd(`VCARB_OFF_RES0_CAP, 32'h1);
        rd(`VCARB_OFF_CAP_TWO, 32'h0);
        wr(`VCARB_OFF_CTRL, 32'h1, 1'b0);
        chk({29'h0, sel_o}, 32'h0);
        rd(`VCARB_OFF_CTRL, 32'h0);
        wr(`VCARB_OFF_CTRL, 32'hffffffff, 1'b0);
        chk({29'h0, sel_o}, 32'h7);
        rd(`VCARB_OFF_CTRL, 32'he);
        wr(`VCARB_OFF_STAT, 32'hffffffff, 1'b0);
        rd(`VCARB_OFF_STAT, 32'h0);
        wr(`VCARB_OFF_RES0_CAP, 32'hffffffff, 1'b0);
        rd(`VCARB_OFF_RES0_CAP, 32'h1);
        wr(`VCARB_OFF_RES0_CAP, 32'hffffffff, 1'b1);
        rd(`VCARB_OFF_RES0_CAP, 32'hff0000ff);
        chk({24'h0, pcap_o}, 32'hff);
        @(posedge clk_i);
        cnt_i <= 3'h1;
        #1 chk(rdata_o, 32'h0);
        wr(`VCARB_OFF_CAP_TWO, 32'hffffffff, 1'b0);
        rd(`VCARB_OFF_CAP_TWO, 32'h000000a5);
        rd(12'h300, 32'h0);
        results;
    end
    // the whole sequence needs well under a thousand cycles
    initial begin
        #20000;
        n_errors++;
        results;
    end
endmodule
